// ===== src/dbss_pkg.sv
/*
 * Types shared by the sequencer top and its per-section controller.
 * Assumes nothing beyond the timing header.
 */
package dbss_pkg;

	typedef enum logic [1:0]
	{
		DBSS_OFF     = 2'b00,
		DBSS_BLANK   = 2'b01,
		DBSS_ON      = 2'b10,
		DBSS_HALT    = 2'b11
	} dbss_top_type;

	typedef enum logic [2:0]
	{
		DBSS_IDLE    = 3'b000,
		DBSS_SOFT    = 3'b001,
		DBSS_RUN     = 3'b010,
		DBSS_SOFTEND = 3'b011,
		DBSS_GROUND  = 3'b100
	} dbss_sec_type;

	// Synchronised enable and comparator results of one section
	typedef struct packed
	{
		logic enable;
		logic in_window;
		logic over_v;
		logic under_v;
		logic below_discharge;
	} dbss_sense_type;

	// Drive requests of one section
	typedef struct packed
	{
		logic       high_drive;
		logic       low_drive;
		logic       discharge;
		logic       output_ok;
		logic [2:0] ilim_quarters;
	} dbss_drive_type;

endpackage

// ===== src/dbss_regs.svh
/*
 * Timing constants for the dual buck sequencer and fault supervisor.
 * Assumes a 50 MHz reference clock.
 */
`ifndef DBSS_REGS_SVH
`define DBSS_REGS_SVH

`define DBSS_CLK_HZ           50000000
`define DBSS_TICK_NS          20
`define DBSS_TICK_CYC         50
`define DBSS_BLANK_MS         4
`define DBSS_BLANK_US         4000
`define DBSS_STEP_US          700
`define DBSS_STEPS            4
`define DBSS_ILIM_W           3

`endif

// ===== src/dbss_section.sv
/*
 * One switching section: soft start, run, soft end and latched faults.
 * Assumes synchronised inputs and a shared time-base tick.
 */
`timescale 1ns/100ps
`include "dbss_regs.svh"

module dbss_section
#(
	parameter int STEP_TICKS = `DBSS_STEP_US
)
(
	input  wire logic                    ref_clk,
	input  wire logic                    nrst,
	input  wire logic                    tick,
	input  wire logic                    powered,
	input  wire logic                    restart,
	input  wire dbss_pkg::dbss_sense_type sense,
	output      dbss_pkg::dbss_drive_type drive
);

	// The step counter is sixteen bits wide
	if (STEP_TICKS < 1 || STEP_TICKS > 65536)
	begin
		$error("STEP_TICKS must lie in 1..65536");
	end

	dbss_pkg::dbss_sec_type state_reg;
	logic [15:0]            step_cnt_reg;
	logic [2:0]             quarter_reg;
	logic                   ov_reg;
	logic                   uv_reg;
	logic                   en_d_reg;
	logic                   en_fall;

	assign en_fall = en_d_reg & ~sense.enable;

	always_ff @(posedge ref_clk)
		if (!nrst)
			en_d_reg <= 1'b0;
		else
			en_d_reg <= sense.enable;

	////////////////////////////////////////////////////////////////////
	// Fault latches; set wins over an enable-fall clear in the same cycle, reset, restart and power loss win over set

	always_ff @(posedge ref_clk)
		if (!nrst || restart || !powered)
			ov_reg <= 1'b0;
		else if (sense.over_v && state_reg != dbss_pkg::DBSS_IDLE)
			ov_reg <= 1'b1;
		else if (en_fall)
			ov_reg <= 1'b0;

	always_ff @(posedge ref_clk)
		if (!nrst || restart || !powered)
			uv_reg <= 1'b0;
		else if (sense.under_v && state_reg == dbss_pkg::DBSS_RUN)
			uv_reg <= 1'b1;
		else if (en_fall)
			uv_reg <= 1'b0;

	////////////////////////////////////////////////////////////////////
	// Sequencing

	always_ff @(posedge ref_clk)
		if (!nrst || !powered)
		begin
			state_reg    <= dbss_pkg::DBSS_IDLE;
			step_cnt_reg <= 16'h0000;
			quarter_reg  <= 3'h1;
		end
		else
			case (state_reg)
				dbss_pkg::DBSS_IDLE:
					if (sense.enable && !ov_reg && !uv_reg)
					begin
						state_reg    <= dbss_pkg::DBSS_SOFT;
						step_cnt_reg <= 16'h0000;
						quarter_reg  <= 3'h1;
					end
				dbss_pkg::DBSS_SOFT:
					if (!sense.enable || ov_reg)
						state_reg <= dbss_pkg::DBSS_SOFTEND;
					else if (tick)
					begin
						if (step_cnt_reg == 16'(STEP_TICKS - 1))
						begin
							step_cnt_reg <= 16'h0000;
							if (quarter_reg == 3'(`DBSS_STEPS))
								state_reg <= dbss_pkg::DBSS_RUN;
							else
								quarter_reg <= quarter_reg + 3'h1;
						end
						else
							step_cnt_reg <= step_cnt_reg + 16'h0001;
					end
				dbss_pkg::DBSS_RUN:
					if (!sense.enable || uv_reg || ov_reg ||
						(sense.under_v))
						state_reg <= dbss_pkg::DBSS_SOFTEND;
				dbss_pkg::DBSS_SOFTEND:
					if (sense.below_discharge)
						state_reg <= dbss_pkg::DBSS_GROUND;
				dbss_pkg::DBSS_GROUND:
					if (!sense.enable && !ov_reg && !uv_reg)
						state_reg <= dbss_pkg::DBSS_IDLE;
					else if (sense.enable && !en_d_reg)
						state_reg <= dbss_pkg::DBSS_IDLE;
				default:
					state_reg <= dbss_pkg::DBSS_IDLE;
			endcase

	////////////////////////////////////////////////////////////////////
	// Drive requests

	always_ff @(posedge ref_clk)
		if (!nrst)
			drive <= '{1'b0, 1'b0, 1'b0, 1'b0, 3'h0};
		else
		begin
			drive.ilim_quarters <= quarter_reg;
			drive.discharge <= state_reg == dbss_pkg::DBSS_SOFTEND &&
				!sense.over_v && !ov_reg;
			drive.output_ok <= state_reg == dbss_pkg::DBSS_RUN &&
				sense.in_window && !ov_reg && !uv_reg;
			if (!powered)
			begin
				drive.high_drive <= 1'b0;
				drive.low_drive  <= 1'b0;
			end
			else if (sense.over_v || ov_reg)
			begin
				drive.high_drive <= 1'b0;
				drive.low_drive  <= 1'b1;
			end
			else if (state_reg == dbss_pkg::DBSS_SOFT ||
				state_reg == dbss_pkg::DBSS_RUN)
			begin
				drive.high_drive <= 1'b1;
				drive.low_drive  <= 1'b0;
			end
			else if (state_reg == dbss_pkg::DBSS_SOFTEND)
			begin
				drive.high_drive <= 1'b0;
				drive.low_drive  <= 1'b0;
			end
			else
			begin
				drive.high_drive <= 1'b0;
				drive.low_drive  <= 1'b1;
			end
		end

endmodule

// ===== src/dbss_top.sv
/*
 * Top of the dual buck sequencer and fault supervisor.
 * Assumes comparator outputs arrive asynchronously as single bits.
 */
// Overview of operation
// - Shutdown rising starts power-up, clears faults
// - Blank regulator lockout 4 ms, then standby
// - Standby: shutdown high, enables low, regulator on
// - Standby: low drives high, high drives low
// - Enable high while powered starts soft start
// - Run: enabled sections and regulator active
// - Shutdown low keeps everything off
// - Output ok low outside window
// - Output ok low in soft start/end, standby
// - Over-temperature turns off after discharge
// - Thermal trip clears by shutdown toggle or reset only
// - Overvoltage latches, low on, high off
// - Overvoltage armed during soft start
// - Overvoltage holds low drive, regulator running
// - Overvoltage clears on shutdown/enable toggle, reset
// - Undervoltage latches, opens both switches
// - Undervoltage: soft end then low drive high
// - Undervoltage disarmed until soft start done
// - Toggle clears undervoltage, fresh soft start
// - Current limit rises quarter steps, 700 us
// - Soft end discharges, grounds below threshold
// - Regulator below fault level turns all off
// - Reference below fault level turns all off
`timescale 1ns/100ps
`include "dbss_regs.svh"

module dbss_top
#(
	parameter int TICK_CYC   = `DBSS_TICK_CYC,
	parameter int BLANK_TICK = `DBSS_BLANK_US,
	parameter int STEP_TICK  = `DBSS_STEP_US
)
(
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       shutdown_control_n,
	input  wire logic       section_enable_1,
	input  wire logic       section_enable_2,
	input  wire logic       regulator_above_lockout,
	input  wire logic       regulator_above_fault,
	input  wire logic       reference_above_fault,
	input  wire logic       over_temperature,
	input  wire logic [1:0] output_in_window,
	input  wire logic [1:0] output_over_v,
	input  wire logic [1:0] output_under_v,
	input  wire logic [1:0] output_below_discharge,
	output      logic       internal_5v_regulator,
	output      logic       output_ok_1,
	output      logic       output_ok_2,
	output      logic       low_side_drive_1,
	output      logic       low_side_drive_2,
	output      logic       high_side_drive_1,
	output      logic       high_side_drive_2,
	output      logic [1:0] discharge_on,
	output      logic [5:0] current_limit_quarters,
	output      logic       thermal_fault
);

	// Counter widths bound what the timing parameters may ask for
	if (TICK_CYC < 1 || TICK_CYC > 256)
	begin
		$error("TICK_CYC must lie in 1..256");
	end

	if (BLANK_TICK < 1 || BLANK_TICK > 65536)
	begin
		$error("BLANK_TICK must lie in 1..65536");
	end

	if (STEP_TICK < 1 || STEP_TICK > 65536)
	begin
		$error("STEP_TICK must lie in 1..65536");
	end

	// Seven single pins and four two-bit section buses
	localparam int NSYNC = 15;

	////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers

	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] meta_reg;
	logic [NSYNC-1:0] sync_reg;

	assign async_in = {shutdown_control_n, section_enable_1,
		section_enable_2, regulator_above_lockout, regulator_above_fault,
		reference_above_fault, over_temperature, output_in_window,
		output_over_v, output_under_v, output_below_discharge};

	always_ff @(posedge ref_clk)
		if (!nrst)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end

	logic       shutdown_control_n_s;
	logic [1:0] en_s;
	logic       lock_s;
	logic       regf_s;
	logic       reff_s;
	logic       hot_s;
	logic [1:0] win_s;
	logic [1:0] ov_s;
	logic [1:0] uv_s;
	logic [1:0] dis_s;

	// Positions follow the order of async_in, top bit first
	assign shutdown_control_n_s = sync_reg[14];
	assign en_s   = {sync_reg[12], sync_reg[13]};
	assign lock_s = sync_reg[11];
	assign regf_s = sync_reg[10];
	assign reff_s = sync_reg[9];
	assign hot_s  = sync_reg[8];
	assign win_s  = sync_reg[7:6];
	assign ov_s   = sync_reg[5:4];
	assign uv_s   = sync_reg[3:2];
	assign dis_s  = sync_reg[1:0];

	////////////////////////////////////////////////////////////////////
	// Free-running 1 us time base

	// One-cycle enable pulse; every slow interval counts these
	logic [7:0] tick_cnt_reg;
	logic       tick_reg;

	always_ff @(posedge ref_clk)
		if (!nrst)
		begin
			tick_cnt_reg <= 8'h00;
			tick_reg     <= 1'b0;
		end
		else if (tick_cnt_reg == 8'(TICK_CYC - 1))
		begin
			tick_cnt_reg <= 8'h00;
			tick_reg     <= 1'b1;
		end
		else
		begin
			tick_cnt_reg <= tick_cnt_reg + 8'h01;
			tick_reg     <= 1'b0;
		end

	////////////////////////////////////////////////////////////////////
	// Power-up sequencing

	dbss_pkg::dbss_top_type top_reg;
	logic [15:0]            blank_cnt_reg;
	logic                   shutdown_control_n_d_reg;
	logic                   shutdown_control_n_rise;
	logic                   powered;
	logic                   global_fault;
	logic [1:0]             sec_busy;

	// Supply faults act once ON; BLANK watches the reference alone
	assign shutdown_control_n_rise    = shutdown_control_n_s & ~shutdown_control_n_d_reg;
	assign global_fault = !regf_s || !reff_s;
	assign powered      = top_reg == dbss_pkg::DBSS_ON;

	always_ff @(posedge ref_clk)
		if (!nrst)
			shutdown_control_n_d_reg <= 1'b0;
		else
			shutdown_control_n_d_reg <= shutdown_control_n_s;

	always_ff @(posedge ref_clk)
		if (!nrst || !shutdown_control_n_s)
		begin
			top_reg       <= dbss_pkg::DBSS_OFF;
			blank_cnt_reg <= 16'h0000;
		end
		else
			case (top_reg)
				dbss_pkg::DBSS_OFF:
					if (shutdown_control_n_rise)
					begin
						top_reg       <= dbss_pkg::DBSS_BLANK;
						blank_cnt_reg <= 16'h0000;
					end
				dbss_pkg::DBSS_BLANK:
					if (!reff_s)
						top_reg <= dbss_pkg::DBSS_HALT;
					else if (tick_reg)
					begin
						if (blank_cnt_reg == 16'(BLANK_TICK - 1))
							top_reg <= lock_s ? dbss_pkg::DBSS_ON
								: dbss_pkg::DBSS_HALT;
						else
							blank_cnt_reg <= blank_cnt_reg + 16'h0001;
					end
				dbss_pkg::DBSS_ON:
					if (global_fault)
						top_reg <= dbss_pkg::DBSS_HALT;
					else if (hot_s)
						top_reg <= dbss_pkg::DBSS_HALT;
				dbss_pkg::DBSS_HALT:
					top_reg <= dbss_pkg::DBSS_HALT;
				default:
					top_reg <= dbss_pkg::DBSS_OFF;
			endcase

	always_ff @(posedge ref_clk)
		if (!nrst || shutdown_control_n_rise)
			thermal_fault <= 1'b0;
		else if (hot_s && powered)
			thermal_fault <= 1'b1;

	////////////////////////////////////////////////////////////////////
	// Thermal discharge hold-up
	// A thermal trip drops the regulator and sequencer at once, but each
	// section is kept alive until its soft end has pulled the output
	// below the discharge level. Cutting the gates earlier would leave
	// a charged output floating until the load drains it.

	logic [1:0] sec_powered;
	logic [1:0] sec_enable;

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : hold
			logic hold_reg;

			always_ff @(posedge ref_clk)
				if (!nrst || !shutdown_control_n_s)
					hold_reg <= 1'b0;
				else if (powered && hot_s && !global_fault)
					hold_reg <= 1'b1;
				else if (dis_s[g])
					hold_reg <= 1'b0;

			// Enable drops with power so a held section runs soft end
			assign sec_powered[g] = powered || hold_reg;
			assign sec_enable[g]  = en_s[g] && powered;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Sections

	dbss_pkg::dbss_drive_type drv [2];
	logic [1:0]               ok_reg;
	logic [1:0]               lo_reg;
	logic [1:0]               hi_reg;

	generate
		for (g = 0; g < 2; g++)
		begin : sec
			dbss_pkg::dbss_sense_type sn;
			assign sn = '{sec_enable[g], win_s[g], ov_s[g], uv_s[g],
				dis_s[g]};
			dbss_section
			#(
				.STEP_TICKS (STEP_TICK)
			)
			u_sec
			(
				.ref_clk (ref_clk),
				.nrst    (nrst),
				.tick    (tick_reg),
				.powered (sec_powered[g]),
				.restart (shutdown_control_n_rise),
				.sense   (sn),
				.drive   (drv[g])
			);
			assign sec_busy[g] = drv[g].discharge;
			assign ok_reg[g]   = drv[g].output_ok;
			assign lo_reg[g]   = drv[g].low_drive;
			assign hi_reg[g]   = drv[g].high_drive;
		end
	endgenerate

	// Outputs come from section flops; regulator flop here
	always_ff @(posedge ref_clk)
		if (!nrst)
			internal_5v_regulator <= 1'b0;
		else
			internal_5v_regulator <= top_reg == dbss_pkg::DBSS_BLANK ||
				powered;

	assign output_ok_1            = ok_reg[0];
	assign output_ok_2            = ok_reg[1];
	assign low_side_drive_1       = lo_reg[0];
	assign low_side_drive_2       = lo_reg[1];
	assign high_side_drive_1      = hi_reg[0];
	assign high_side_drive_2      = hi_reg[1];
	assign discharge_on           = sec_busy;
	assign current_limit_quarters = {drv[1].ilim_quarters,
		drv[0].ilim_quarters};

endmodule

// ===== testbench/dbss_plant.sv
/* Output plant of both sections: a level per section that the drives
   move, with the comparator results taken from it.
   Assumes forces come from the bench. */
`timescale 1ns/100ps
module dbss_plant
(
	input  wire logic       ref_clk,
	input  wire logic [1:0] high_on,
	input  wire logic [1:0] sink_on,
	input  wire logic [1:0] force_ov,
	input  wire logic [1:0] force_uv,
	output      logic [1:0] in_window,
	output      logic [1:0] over_v,
	output      logic [1:0] under_v,
	output      logic [1:0] below_dis
);
	// Percent of set point
	int v [2];

	always_ff @(posedge ref_clk)
		for (int i = 0; i < 2; i++)
			if (force_ov[i])
				v[i] <= 120;
			else if (force_uv[i])
				v[i] <= 50;
			else if (high_on[i])
				v[i] <= (v[i] > 90) ? 100 : v[i] + 10;
			else if (sink_on[i])
				v[i] <= (v[i] < 10) ? 0 : v[i] - 10;

	always_comb
		for (int i = 0; i < 2; i++)
		begin
			in_window[i] = v[i] >= 90 && v[i] <= 110;
			over_v[i] = v[i] > 115;
			under_v[i] = v[i] < 70;
			below_dis[i] = v[i] < 10;
		end
endmodule

// ===== testbench/dbss_top_asserts.sv
/* Port checker for the sequencer top.
   Assumes the bench runs small tick and step counts. */
`timescale 1ns/100ps
module dbss_top_asserts
(
	input wire logic       ref_clk,
	input wire logic       nrst,
	input wire logic       shutdown_control_n,
	input wire logic       section_enable_1,
	input wire logic       over_temperature,
	input wire logic [1:0] output_in_window,
	input wire logic [1:0] output_over_v,
	input wire logic [1:0] output_below_discharge,
	input wire logic       internal_5v_regulator,
	input wire logic       output_ok_1,
	input wire logic       low_side_drive_1,
	input wire logic       high_side_drive_1,
	input wire logic [5:0] current_limit_quarters,
	input wire logic       thermal_fault
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	// Inputs pass two sync stages, hence the slack
	sequence s_hot;
		(over_temperature && shutdown_control_n)[*6];
	endsequence
	sequence s_idle;
		(!section_enable_1 && output_below_discharge[0] &&
			internal_5v_regulator && !thermal_fault)[*8];
	endsequence
	property p_off;
		!shutdown_control_n[*6] |->
			!internal_5v_regulator && !high_side_drive_1;
	endproperty
	property p_win;
		!output_in_window[0][*6] |-> !output_ok_1;
	endproperty
	property p_soft;
		current_limit_quarters[2:0] < 3'h4 |-> !output_ok_1;
	endproperty
	property p_step;
		$changed(current_limit_quarters[2:0]) &&
			current_limit_quarters[2:0] != 3'h1 |->
			current_limit_quarters[2:0] ==
			$past(current_limit_quarters[2:0]) + 3'h1;
	endproperty
	property p_hot;
		s_hot |-> ##[0:3] (thermal_fault && !internal_5v_regulator);
	endproperty
	property p_keep;
		shutdown_control_n[*8] ##0 thermal_fault |=> thermal_fault;
	endproperty
	property p_std;
		s_idle ##1 s_idle |-> low_side_drive_1 && !high_side_drive_1;
	endproperty
	property p_ov;
		output_over_v[0] && high_side_drive_1 |->
			##[1:4] (low_side_drive_1 && !high_side_drive_1);
	endproperty
	a_off: assert property (p_off) else $error("on in shutdown");
	a_win: assert property (p_win) else $error("ok out of window");
	a_soft: assert property (p_soft) else $error("ok in soft start");
	a_step: assert property (p_step) else $error("limit step");
	a_hot: assert property (p_hot) else $error("no thermal trip");
	a_keep: assert property (p_keep) else $error("thermal lost");
	a_std: assert property (p_std) else $error("standby drive");
	a_ov: assert property (p_ov) else $error("no ov clamp");
endmodule

bind dbss_top dbss_top_asserts dbss_top_asserts_inst
(
	.ref_clk, .nrst, .shutdown_control_n, .section_enable_1,
	.over_temperature, .output_in_window, .output_over_v,
	.output_below_discharge, .internal_5v_regulator, .output_ok_1,
	.low_side_drive_1, .high_side_drive_1, .current_limit_quarters,
	.thermal_fault
);

// ===== testbench/dbss_top_tb.sv
/* Bench for the sequencer top with a plant on each section.
   Assumes plant and checker are compiled first. */
`timescale 1ns/100ps
module dbss_top_tb;
	logic       ref_clk = 1'b0;
	logic       nrst = 1'b0;
	logic [2:0] ctl = 3'h0;
	logic       regulator_above_lockout = 1'b1;
	logic       regulator_above_fault = 1'b1;
	logic       reference_above_fault = 1'b1;
	logic       over_temperature = 1'b0;
	logic [1:0] force_ov = 2'h0;
	logic [1:0] force_uv = 2'h0;
	logic       shutdown_control_n, section_enable_1, section_enable_2;
	logic [1:0] output_in_window, output_over_v, output_under_v;
	logic [1:0] output_below_discharge, discharge_on;
	logic       internal_5v_regulator, output_ok_1, output_ok_2;
	logic       low_side_drive_1, low_side_drive_2, thermal_fault;
	logic       high_side_drive_1, high_side_drive_2;
	logic [5:0] current_limit_quarters;
	logic [2:0] lim_q = 3'h0;
	time        steps[$];
	int         n_fail = 0;
	int         checked = 0;
	int         seed = 32'h33A9;

	assign {section_enable_2, section_enable_1, shutdown_control_n} = ctl;
	always #10 ref_clk = ~ref_clk;

	dbss_top #(.TICK_CYC(2), .BLANK_TICK(3), .STEP_TICK(3)) dbss_top_inst
	(
		.ref_clk, .nrst, .shutdown_control_n, .section_enable_1,
		.section_enable_2, .regulator_above_lockout,
		.regulator_above_fault, .reference_above_fault, .over_temperature,
		.output_in_window, .output_over_v, .output_under_v,
		.output_below_discharge, .internal_5v_regulator, .output_ok_1,
		.output_ok_2, .low_side_drive_1, .low_side_drive_2,
		.high_side_drive_1, .high_side_drive_2, .discharge_on,
		.current_limit_quarters, .thermal_fault
	);
	dbss_plant dbss_plant_inst
	(
		.ref_clk, .force_ov, .force_uv,
		.high_on({high_side_drive_2, high_side_drive_1}),
		.sink_on(discharge_on | {low_side_drive_2, low_side_drive_1}),
		.in_window(output_in_window), .over_v(output_over_v),
		.under_v(output_under_v), .below_dis(output_below_discharge)
	);

	// Model of step timing: one quarter per 3 ticks of 2 cycles
	always @(negedge ref_clk)
	begin
		if (current_limit_quarters[2:0] != lim_q)
			steps.push_back($time);
		lim_q = current_limit_quarters[2:0];
	end

	task automatic chk(input logic g, input logic e);
		checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("BAD %0t got %b want %b", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic toggle(input logic [2:0] m);
		@(posedge ref_clk);
		ctl <= ctl & ~m;
		cyc(10);
		@(posedge ref_clk);
		ctl <= ctl | m;
		cyc(50);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		#(20 * 10000);
		n_fail++;
		test_done;
	end

	initial
	begin
		cyc(20);
		@(posedge ref_clk);
		nrst <= 1'b1;
		ctl <= {2'($random(seed)), 1'b0};
		cyc(10);
		chk(internal_5v_regulator | high_side_drive_1, 1'b0);
		@(posedge ref_clk);
		ctl <= 3'h1;
		cyc(6);
		chk(internal_5v_regulator, 1'b1);
		cyc(24);
		chk(internal_5v_regulator & low_side_drive_1, 1'b1);
		chk(low_side_drive_2 & ~high_side_drive_2, 1'b1);
		chk(output_ok_1 | output_ok_2, 1'b0);
		$display("done standby");
		@(posedge ref_clk);
		ctl <= 3'h3;
		steps.delete();
		cyc(8);
		chk(high_side_drive_1 & ~output_ok_1, 1'b1);
		chk(current_limit_quarters[2:0] < 3'h4, 1'b1);
		chk(low_side_drive_2, 1'b1);
		cyc(30);
		chk(current_limit_quarters[2:0] == 3'h4, 1'b1);
		chk(steps.size() == 3 && steps[2] - steps[1] == 120, 1'b1);
		chk(steps[1] - steps[0] == 120, 1'b1);
		chk(output_ok_1 & high_side_drive_1, 1'b1);
		$display("done soft start");
		@(posedge ref_clk);
		force_ov <= 2'h1;
		cyc(8);
		chk(low_side_drive_1 & ~high_side_drive_1, 1'b1);
		chk(output_ok_1, 1'b0);
		@(posedge ref_clk);
		force_ov <= 2'h0;
		cyc(20);
		chk(low_side_drive_1 & internal_5v_regulator, 1'b1);
		toggle(3'h2);
		chk(output_ok_1, 1'b1);
		@(posedge ref_clk);
		ctl <= 3'h7;
		cyc(8);
		chk(high_side_drive_2, 1'b1);
		chk(current_limit_quarters[5:3] == 3'h1, 1'b1);
		@(posedge ref_clk);
		force_ov <= 2'h2;
		cyc(8);
		chk(low_side_drive_2 & ~high_side_drive_2, 1'b1);
		chk(output_ok_1, 1'b1);
		@(posedge ref_clk);
		force_ov <= 2'h0;
		ctl <= 3'h3;
		$display("done overvoltage");
		@(posedge ref_clk);
		force_uv <= 2'h1;
		cyc(8);
		chk(high_side_drive_1 | low_side_drive_1, 1'b0);
		chk(discharge_on[0], 1'b1);
		@(posedge ref_clk);
		force_uv <= 2'h0;
		cyc(20);
		chk(low_side_drive_1 & internal_5v_regulator, 1'b1);
		toggle(3'h1);
		chk(output_ok_1, 1'b1);
		$display("done undervoltage");
		@(posedge ref_clk);
		over_temperature <= 1'b1;
		cyc(8);
		chk(thermal_fault & ~internal_5v_regulator, 1'b1);
		chk(discharge_on[0], 1'b1);
		@(posedge ref_clk);
		over_temperature <= 1'b0;
		toggle(3'h2);
		chk(thermal_fault & ~high_side_drive_1, 1'b1);
		toggle(3'h1);
		chk(~thermal_fault & output_ok_1, 1'b1);
		$display("done thermal");
		@(posedge ref_clk);
		regulator_above_lockout <= 1'b0;
		toggle(3'h1);
		chk(high_side_drive_1 | output_ok_1, 1'b0);
		@(posedge ref_clk);
		regulator_above_lockout <= 1'b1;
		toggle(3'h1);
		chk(output_ok_1, 1'b1);
		for (int k = 0; k < 2; k++)
		begin
			@(posedge ref_clk);
			regulator_above_fault <= (k != 0);
			reference_above_fault <= (k == 0);
			cyc(8);
			chk(internal_5v_regulator | high_side_drive_1, 1'b0);
			@(posedge ref_clk);
			{regulator_above_fault, reference_above_fault} <= 2'h3;
			toggle(3'h1);
			chk(output_ok_1, 1'b1);
		end
		$display("done supply faults");
		test_done;
	end
endmodule
